//--- inc/fos_pkg.sv
/*
 * Shared constants for the one-time field and program command sequencer.
 * Assumes a 32-bit APB slave and a 16-bit word flash array port.
 */
package fos_pkg;
   localparam int WORDS = 4;
   localparam int NOPS  = 6;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_IDX  = 8'h04;
   localparam logic [7:0] OFS_OPER = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_PROT = 8'h10;
   // ------------------------------------------------------------
   // Status bit positions, and the protect enable bit of the PROT register
   // ------------------------------------------------------------
   localparam int B_CCF = 7;
   localparam int B_ACC = 5;
   localparam int B_PV  = 4;
   localparam int B_ME  = 1;
   localparam int B_MU  = 0;
   localparam int B_PEN = 31;
   // ------------------------------------------------------------
   // Mode permit bits
   // ------------------------------------------------------------
   localparam int M_RDO = 0;
   localparam int M_PGM = 1;
   localparam int M_PGO = 2;
   localparam logic [2:0] MODE_RST = 3'h7;
   // ------------------------------------------------------------
   // Commands and operand layout
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_RDO = 8'h04;
   localparam logic [7:0] CMD_PGM = 8'h06;
   localparam logic [7:0] CMD_PGO = 8'h07;
   localparam logic [2:0] IX_ONE  = 3'h1;
   localparam logic [2:0] IX_FIVE = 3'h5;
   localparam int OP_DAT = 2;
   localparam logic [15:0] PHR_MAX   = 16'h0007;
   localparam logic [17:0] OTP_BASE  = 18'h00000;
   localparam logic [15:0] ERASED    = 16'hFFFF;
   localparam logic [15:0] INVALID   = 16'hDEAD;
   localparam logic [17:0] PROT_RST  = 18'h3FFFF;
   localparam logic [17:0] WORD_STEP = 18'h00002;
endpackage

//--- inc/fos_seq_if.sv
/*
 * Carrier between the command sequencer and its four-word walker.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ns
interface fos_seq_if;
   logic               start;
   logic               wr;
   logic               cmp;
   logic               info;
   logic [17:0]        base;
   logic [3:0][15:0]   wdata;
   logic               done;
   logic [3:0][15:0]   rdata;
   logic               mism;
   logic               err;
   logic               unc;
   modport ctl (output start, wr, cmp, info, base, wdata,
                input done, rdata, mism, err, unc);
   modport seq (input start, wr, cmp, info, base, wdata,
                output done, rdata, mism, err, unc);
endinterface

//--- core/fos_word_seq.sv
/*
 * Walks four consecutive words over the flash array port, writing or
 * reading, and compares read words with the expected data.
 * Assumes the array answers each request with arr_ack.
 */
`timescale 1ns/1ns
module fos_word_seq
   import fos_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   fos_seq_if.seq           s,
   output logic             arr_req,
   output logic             arr_we,
   output logic             arr_info,
   output logic [17:0]      arr_addr,
   output logic [15:0]      arr_wdata,
   input  wire logic [15:0] arr_rdata,
   input  wire logic        arr_ack,
   input  wire logic        arr_err,
   input  wire logic        arr_unc
);
   logic [1:0] cnt_q;
   logic       run_q;
   logic       last;

   assign last      = (cnt_q == 2'(WORDS - 1));
   assign arr_req   = run_q;
   assign arr_we    = s.wr;
   assign arr_info  = s.info;
   assign arr_addr  = s.base + 18'(cnt_q) * WORD_STEP;
   assign arr_wdata = s.wdata[cnt_q];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         cnt_q <= '0;
      end else if (s.start) begin
         run_q <= 1'b1;
         cnt_q <= '0;
      end else if (run_q && arr_ack) begin
         run_q <= !last;
         cnt_q <= cnt_q + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s.done <= 1'b0;
      else
         s.done <= run_q && arr_ack && last;
   end

   // Error sums restart with each walk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.mism  <= 1'b0;
         s.err   <= 1'b0;
         s.unc   <= 1'b0;
         s.rdata <= '0;
      end else if (s.start) begin
         s.mism <= 1'b0;
         s.err  <= 1'b0;
         s.unc  <= 1'b0;
      end else if (run_q && arr_ack && !s.wr) begin
         s.rdata[cnt_q] <= arr_rdata;
         s.mism <= s.mism | (s.cmp && arr_rdata != s.wdata[cnt_q]);
         s.err  <= s.err | arr_err | arr_unc;
         s.unc  <= s.unc | arr_unc;
      end
   end
endmodule

//--- core/fos_launch_chk.sv
/*
 * Launch checks for read-once, program and program-once commands.
 * Purely combinational; assumes operands are stable at launch.
 */
`timescale 1ns/1ns
module fos_launch_chk
   import fos_pkg::*;
#(
   parameter logic [17:0] PF_LO = 18'h30000,
   parameter logic [17:0] PF_HI = 18'h3FFFF
)(
   input  wire logic [7:0]  cmd,
   input  wire logic [2:0]  idx,
   input  wire logic [15:0] op1,
   input  wire logic [17:0] addr,
   input  wire logic [2:0]  mode,
   input  wire logic        prot_en,
   input  wire logic [17:0] prot_from,
   output logic             acc,
   output logic             pviol
);
   function automatic logic phr_ok(input logic [15:0] p);
      return p <= PHR_MAX;
   endfunction

   always_comb begin
      acc   = 1'b0;
      pviol = 1'b0;
      case (cmd)
         CMD_RDO: acc = idx != IX_ONE || !mode[M_RDO]
                        || !phr_ok(op1);
         CMD_PGO: acc = idx != IX_FIVE || !mode[M_PGO]
                        || !phr_ok(op1);
         CMD_PGM: begin
            acc = idx != IX_FIVE || !mode[M_PGM]
                  || addr[2:0] != 3'h0
                  || addr < PF_LO || addr > PF_HI;
            pviol = !acc && prot_en && addr >= prot_from;
         end
         default: acc = 1'b1;
      endcase
   end
endmodule

//--- core/fos_top.sv
/*
 * APB command sequencer for read-once, program and program-once.
 * Assumes an external flash array port with info-area select and
 * a CPU fetch path passed through this block.
 */
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module fos_top
   import fos_pkg::*;
#(
   parameter logic [17:0] PF_LO = 18'h30000,
   parameter logic [17:0] PF_HI = 18'h3FFFF
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             arr_req,
   output logic             arr_we,
   output logic             arr_info,
   output logic [17:0]      arr_addr,
   output logic [15:0]      arr_wdata,
   input  wire logic [15:0] arr_rdata,
   input  wire logic        arr_ack,
   input  wire logic        arr_err,
   input  wire logic        arr_unc,
   input  wire logic [15:0] fetch_in,
   output logic [15:0]      fetch_data,
   output logic             fetch_invalid,
   output logic             command_busy
);
   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE   = 7'b0000001,
      ST_CHECK  = 7'b0000010,
      ST_BLANK  = 7'b0000100,
      ST_WRITE  = 7'b0001000,
      ST_VERIFY = 7'b0010000,
      ST_FETCH  = 7'b0100000,
      ST_DONE   = 7'b1000000
   } fos_state_t;

   fos_state_t        state_q;
   fos_state_t        state_d;
   logic [15:0]       command_operand_regs_q [NOPS];
   logic [2:0]        operand_index_q;
   logic [2:0]        mode_q;
   logic              prot_en_q;
   logic [17:0]       prot_from_q;
   logic              command_complete_flag_q;
   logic              access_error_flag_q;
   logic              protection_violation_flag_q;
   logic              margin_status_error_q;
   logic              margin_status_uncorrectable_q;
   logic              start_q;
   logic              wr_acc;
   logic              rd_acc;
   logic              launch;
   logic              chk_acc;
   logic              chk_pv;
   logic              otp_busy;
   logic              acc_set;
   logic              pv_set;
   logic              me_set;
   logic              mu_set;
   logic [7:0]        cmd;
   logic [17:0]       paddr18;
   logic [17:0]       otp_addr;
   logic [31:0]       stat_rd;

   fos_seq_if sif ();

   assign cmd      = command_operand_regs_q[0][15:8];
   assign paddr18  = {command_operand_regs_q[0][1:0],
                      command_operand_regs_q[1]};
   assign otp_addr = OTP_BASE
                     + {12'h000, command_operand_regs_q[1][2:0], 3'h0};

   // ------------------------------------------------------------
   // APB slave, zero wait states
   // ------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign launch = wr_acc && paddr == OFS_STAT && pwdata[B_CCF]
                   && command_complete_flag_q;

   always_comb begin
      case (paddr)
         OFS_STAT, OFS_IDX, OFS_OPER, OFS_MODE, OFS_PROT: pslverr = 1'b0;
         default: pslverr = psel && penable;
      endcase
   end

   always_comb begin
      stat_rd        = '0;
      stat_rd[B_CCF] = command_complete_flag_q;
      stat_rd[B_ACC] = access_error_flag_q;
      stat_rd[B_PV]  = protection_violation_flag_q;
      stat_rd[B_ME]  = margin_status_error_q;
      stat_rd[B_MU]  = margin_status_uncorrectable_q;
   end

   always_comb begin
      prdata = '0;
      if (rd_acc) begin
         case (paddr)
            OFS_STAT: prdata = stat_rd;
            OFS_IDX:  prdata = {29'h0, operand_index_q};
            OFS_OPER: prdata = operand_index_q < 3'(NOPS)
                               ? {16'h0,
                                  command_operand_regs_q[operand_index_q]}
                               : '0;
            OFS_MODE: prdata = {29'h0, mode_q};
            OFS_PROT: prdata = {prot_en_q, 13'h0, prot_from_q};
            default:  prdata = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operand_index_q <= '0;
         mode_q          <= MODE_RST;
         prot_en_q       <= 1'b0;
         prot_from_q     <= PROT_RST;
      end else if (wr_acc && command_complete_flag_q) begin
         // Settings stay frozen while a command runs
         case (paddr)
            OFS_IDX:  operand_index_q <= pwdata[2:0];
            OFS_MODE: mode_q <= pwdata[2:0];
            OFS_PROT: begin
               prot_en_q   <= pwdata[B_PEN];
               prot_from_q <= pwdata[17:0];
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Operand registers
   // ------------------------------------------------------------
   for (genvar i = 0; i < NOPS; i++) begin : g_op
      // Clamped so slots 0 and 1 never select outside the walker data
      localparam int RI = i >= OP_DAT ? i - OP_DAT : 0;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            command_operand_regs_q[i] <= '0;
         else if (state_q == ST_FETCH && sif.done && i >= OP_DAT)
            command_operand_regs_q[i] <=
               sif.rdata[RI];
         else if (wr_acc && paddr == OFS_OPER && command_complete_flag_q
                  && operand_index_q == 3'(i))
            command_operand_regs_q[i] <= pwdata[15:0];
      end
   end

   // ------------------------------------------------------------
   // Launch checks
   // ------------------------------------------------------------
   fos_launch_chk #(
      .PF_LO     (PF_LO),
      .PF_HI     (PF_HI)
   ) u_chk (
      .cmd       (cmd),
      .idx       (operand_index_q),
      .op1       (command_operand_regs_q[1]),
      .addr      (paddr18),
      .mode      (mode_q),
      .prot_en   (prot_en_q),
      .prot_from (prot_from_q),
      .acc       (chk_acc),
      .pviol     (chk_pv)
   );

   // ------------------------------------------------------------
   // Command state machine
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (launch) state_d = ST_CHECK;
         ST_CHECK: begin
            if (chk_acc || chk_pv)
               state_d = ST_DONE;
            else if (cmd == CMD_RDO)
               state_d = ST_FETCH;
            else if (cmd == CMD_PGO)
               state_d = ST_BLANK;
            else
               state_d = ST_WRITE;
         end
         ST_BLANK: begin
            if (sif.done)
               state_d = sif.mism ? ST_DONE : ST_WRITE;
         end
         ST_WRITE:  if (sif.done) state_d = ST_VERIFY;
         ST_VERIFY: if (sif.done) state_d = ST_DONE;
         ST_FETCH:  if (sif.done) state_d = ST_DONE;
         ST_DONE:   state_d = ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Walker start pulses on entry to each array phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         start_q <= 1'b0;
      else
         start_q <= state_d != state_q
                    && (state_d == ST_BLANK || state_d == ST_WRITE
                        || state_d == ST_VERIFY || state_d == ST_FETCH);
   end

   assign sif.start = start_q;
   assign sif.wr    = state_q == ST_WRITE;
   assign sif.cmp   = state_q == ST_BLANK || state_q == ST_VERIFY;
   assign sif.info  = cmd != CMD_PGM;
   assign sif.base  = cmd == CMD_PGM ? paddr18 : otp_addr;

   always_comb begin
      for (int w = 0; w < WORDS; w++)
         sif.wdata[w] = state_q == ST_BLANK
                        ? ERASED
                        : command_operand_regs_q[OP_DAT + w];
   end

   fos_word_seq u_seq (
      .pclk      (pclk),
      .presetn   (presetn),
      .s         (sif),
      .arr_req   (arr_req),
      .arr_we    (arr_we),
      .arr_info  (arr_info),
      .arr_addr  (arr_addr),
      .arr_wdata (arr_wdata),
      .arr_rdata (arr_rdata),
      .arr_ack   (arr_ack),
      .arr_err   (arr_err),
      .arr_unc   (arr_unc)
   );

   // ------------------------------------------------------------
   // Status flags, set wins over clear
   // ------------------------------------------------------------
   assign acc_set = (state_q == ST_CHECK && chk_acc)
                    || (state_q == ST_BLANK && sif.done
                        && sif.mism);
   assign pv_set  = state_q == ST_CHECK && chk_pv;
   assign me_set  = sif.done && (state_q == ST_FETCH
                    || state_q == ST_VERIFY)
                    && (sif.err || (state_q == ST_VERIFY
                        && sif.mism));
   assign mu_set  = sif.done && sif.unc && (state_q == ST_FETCH
                    || state_q == ST_VERIFY);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         command_complete_flag_q <= 1'b1;
      else if (state_q == ST_DONE)
         command_complete_flag_q <= 1'b1;
      else if (launch)
         command_complete_flag_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         access_error_flag_q         <= 1'b0;
         protection_violation_flag_q <= 1'b0;
      end else begin
         access_error_flag_q <= acc_set || (access_error_flag_q
            && !(wr_acc && paddr == OFS_STAT && pwdata[B_ACC]));
         protection_violation_flag_q <= pv_set
            || (protection_violation_flag_q
                && !(wr_acc && paddr == OFS_STAT && pwdata[B_PV]));
      end
   end

   // Margin flags describe the latest command only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         margin_status_error_q         <= 1'b0;
         margin_status_uncorrectable_q <= 1'b0;
      end else if (launch) begin
         margin_status_error_q         <= 1'b0;
         margin_status_uncorrectable_q <= 1'b0;
      end else begin
         margin_status_error_q <= margin_status_error_q | me_set;
         margin_status_uncorrectable_q <=
            margin_status_uncorrectable_q | mu_set;
      end
   end

   // ------------------------------------------------------------
   // CPU fetch path
   // ------------------------------------------------------------
   assign otp_busy = !command_complete_flag_q && cmd != CMD_PGM;
   assign command_busy = !command_complete_flag_q;

   // Software must keep its code outside this array here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_data    <= '0;
         fetch_invalid <= 1'b0;
      end else begin
         fetch_data    <= otp_busy ? INVALID : fetch_in;
         fetch_invalid <= otp_busy;
      end
   end
endmodule

//--- verif/fos_top_monitor.sv
/* Port checker for fos_top.
   Assumes it is bound to fos_top and sees only its ports. */
`timescale 1ns/1ns
module fos_top_monitor
   import fos_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        arr_req,
   input wire logic        arr_we,
   input wire logic        arr_info,
   input wire logic [17:0] arr_addr,
   input wire logic        arr_ack,
   input wire logic [15:0] fetch_in,
   input wire logic [15:0] fetch_data,
   input wire logic        fetch_invalid,
   input wire logic        command_busy
);
   // ------------------------------------------------------------
   // Launch tracking
   // ------------------------------------------------------------
   logic       go;
   logic       map;
   logic [2:0] idx_q;
   assign go = psel && penable && pwrite && paddr == OFS_STAT
               && pwdata[B_CCF] && !command_busy;
   assign map = paddr inside {OFS_STAT, OFS_IDX, OFS_OPER, OFS_MODE,
                              OFS_PROT};
   // Index writes are dropped while busy, so mirror that
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= 3'h0;
      end else if (psel && penable && pwrite && paddr == OFS_IDX
                   && !command_busy) begin
         idx_q <= pwdata[2:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Refusal: check cycle, then done cycle, no array traffic
   sequence s_busy2;
      (command_busy && !arr_req)[*2];
   endsequence
   sequence s_ack_next;
      arr_req && arr_ack ##1 arr_req;
   endsequence
   AST_LAUNCH: assert property (go |=> command_busy)
      else $error("launch did not set busy");
   AST_REFUSE: assert property (go && idx_q == 3'h0
      |=> s_busy2 ##1 !command_busy) else $error("refusal timing wrong");
   AST_IDLE: assert property (!command_busy |-> !arr_req)
      else $error("array request while idle");
   AST_HOLD: assert property (arr_req && !arr_ack
      |=> arr_req && $stable(arr_addr) && $stable(arr_we))
      else $error("array request dropped or changed");
   AST_STEP: assert property (s_ack_next
      |-> arr_addr == $past(arr_addr) + WORD_STEP)
      else $error("word address did not step");
   AST_INVAL: assert property (arr_req && arr_info
      |=> fetch_invalid && fetch_data == INVALID)
      else $error("fetch not invalid during one-time access");
   AST_PASS: assert property (!command_busy
      |=> !fetch_invalid && fetch_data == $past(fetch_in))
      else $error("fetch not passed through while idle");
   AST_UNMAP: assert property (psel && penable && !map
      |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
endmodule

//--- verif/tb_top.sv
/* Bench for fos_top: APB master, flash array model, result queues.
   Assumes fos_pkg offsets and a 100 MHz pclk. */
`timescale 1ns/1ns
module tb_top
   import fos_pkg::*;
;
   logic             pclk, presetn, psel, penable, pwrite, pready;
   logic             pslverr, arr_req, arr_we, arr_info, arr_ack;
   logic             arr_err, arr_unc, fetch_invalid, command_busy;
   logic             inj_e, inj_u, ack_d;
   logic [7:0]       paddr;
   logic [15:0]      arr_wdata, arr_rdata, fetch_in, fetch_data;
   logic [17:0]      arr_addr;
   logic [31:0]      pwdata, prdata;
   logic [63:0]      d;
   logic [34:0]      eq[$], mq[$], wq[$];
   logic [15:0]      mem[logic [18:0]];
   int               errors, n_compared, seed;
   localparam logic [34:0] SM = 35'h1000000B3;
   localparam logic [34:0] DM = 35'h1FFFFFFFF;
   localparam logic [15:0] RO = {CMD_RDO, 8'h00};
   localparam logic [15:0] PO = {CMD_PGO, 8'h00};
   localparam logic [15:0] PG = {CMD_PGM, 8'h03};
   fos_top u_fos_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .arr_req, .arr_we, .arr_info,
      .arr_addr, .arr_wdata, .arr_rdata, .arr_ack, .arr_err, .arr_unc,
      .fetch_in, .fetch_data, .fetch_invalid, .command_busy);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cmp(input logic [34:0] g, e, m);
      n_compared++;
      if (((g ^ e) & m) !== 35'h0) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic final_report;
      if (errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [32:0] v, input logic [34:0] m);
      if (!w) begin
         eq.push_back({2'b0, v});
         mq.push_back(m);
      end
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= a; pwdata <= v[31:0];
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, {1'b0, v}, 35'h0);
   endtask
   function automatic logic [32:0] st(input logic a, p, e, u);
      return {25'h0, 1'b1, 1'b0, a, p, 2'b0, e, u};
   endfunction
   task automatic ew(input logic i, input logic [17:0] a,
                     input logic [63:0] v);
      for (int k = 0; k < 4; k++) begin
         wq.push_back({i, a + 18'(2 * k), v[16*k +: 16]});
      end
   endtask
   task automatic go(input logic [5:0][15:0] op, input logic [2:0] ix);
      for (int k = 0; k < 6; k++) begin
         wr(OFS_IDX, 32'(k));
         wr(OFS_OPER, {16'h0, op[k]});
      end
      wr(OFS_IDX, {29'h0, ix});
      wr(OFS_STAT, 32'h30);
      wr(OFS_STAT, 32'h80);
   endtask
   task automatic wt;
      int k;
      for (k = 0; k < 500 && command_busy !== 1'b0; k++) @(posedge pclk);
      if (k == 500) begin
         errors++;
         $display("[ERR] %0t busy stuck", $time);
      end
   endtask
   task automatic rs(input logic [63:0] v);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_IDX, 32'(k + OP_DAT));
         apb(1'b0, OFS_OPER, {17'h0, v[16*k +: 16]}, DM);
      end
   endtask
   // Refused launches: no array writes may follow
   task automatic er(input logic [15:0] o0, o1, input logic [2:0] ix, md,
                     input logic a, p);
      wr(OFS_MODE, {29'h0, md});
      go({{$random(seed), $random(seed)}, o1, o0}, ix);
      wt;
      apb(1'b0, OFS_STAT, st(a, p, 1'b0, 1'b0), SM);
      wr(OFS_MODE, 32'h7);
   endtask
   // ------------------------------------------------------------
   // Clock, array model, checkers
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      fetch_in <= 16'($random(seed));
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         cmp({2'b0, pslverr, prdata}, eq.pop_front(), mq.pop_front());
      end
      // Random stall: acks come one or more cycles late
      ack_d = arr_req === 1'b1 && !arr_ack && $random(seed) % 2 == 0;
      arr_ack <= ack_d;
      if (ack_d) begin
         arr_err <= inj_e;
         arr_unc <= inj_u;
         arr_rdata <= mem.exists({arr_info, arr_addr}) ?
                      mem[{arr_info, arr_addr}] : ERASED;
         if (arr_we) begin
            cmp({arr_info, arr_addr, arr_wdata}, wq.pop_front(), '1);
            mem[{arr_info, arr_addr}] = arr_wdata;
         end
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      final_report;
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {inj_e, inj_u, errors} = '0;
      n_compared = 0;
      seed = 32'h3E58;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFS_STAT, st(0, 0, 0, 0), SM);
      apb(1'b0, 8'h14, 33'h100000000, DM);
      wr(OFS_PROT, 32'h80000000);
      d = {$random(seed), $random(seed)};
      ew(1'b1, OTP_BASE + 18'd24, d);
      go({d, 16'h0003, PO}, IX_FIVE);
      while (arr_req !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      cmp({19'h0, fetch_data}, {19'h0, INVALID}, 35'hFFFF);
      wt;
      apb(1'b0, OFS_STAT, st(0, 0, 0, 0), SM);
      go({~d, 16'h0003, RO}, IX_ONE);
      wt;
      rs(d);
      go({~d, 16'h0003, PO}, IX_FIVE);
      wt;
      apb(1'b0, OFS_STAT, st(1, 0, 0, 0), SM);
      ew(1'b1, OTP_BASE + 18'd40, '1);
      go({64'hFFFFFFFFFFFFFFFF, 16'h0005, PO}, IX_FIVE);
      wt;
      ew(1'b1, OTP_BASE + 18'd40, d);
      go({d, 16'h0005, PO}, IX_FIVE);
      wt;
      apb(1'b0, OFS_STAT, st(0, 0, 0, 0), SM);
      for (int k = 0; k < 4; k++) mem[19'h40038 + 19'(2 * k)] = ~d[16*k +: 16];
      inj_e <= 1'b1;
      inj_u <= 1'b1;
      go({d, 16'h0007, RO}, IX_ONE);
      wt;
      {inj_e, inj_u} <= 2'b00;
      apb(1'b0, OFS_STAT, st(0, 0, 1, 1), SM);
      rs(~d);
      wr(OFS_PROT, 32'h80038000);
      ew(1'b0, 18'h30008, d);
      go({d, 16'h0008, PG}, IX_FIVE);
      wt;
      apb(1'b0, OFS_STAT, st(0, 0, 0, 0), SM);
      inj_u <= 1'b1;
      ew(1'b0, 18'h30010, ~d);
      go({~d, 16'h0010, PG}, IX_FIVE);
      wt;
      inj_u <= 1'b0;
      apb(1'b0, OFS_STAT, st(0, 0, 1, 1), SM);
      er(RO, 16'h0008, IX_ONE, 3'h7, 1'b1, 1'b0);
      er(RO, 16'h0000, 3'h0, 3'h7, 1'b1, 1'b0);
      er(RO, 16'h0000, IX_ONE, 3'h6, 1'b1, 1'b0);
      er(PG, 16'h0008, 3'h4, 3'h7, 1'b1, 1'b0);
      er(PG, 16'h0004, IX_FIVE, 3'h7, 1'b1, 1'b0);
      er({CMD_PGM, 8'h01}, 16'h0, IX_FIVE, 3'h7, 1'b1, 1'b0);
      er(PG, 16'h8000, IX_FIVE, 3'h7, 1'b0, 1'b1);
      er(PO, 16'h0008, IX_FIVE, 3'h7, 1'b1, 1'b0);
      er(PO, 16'h0001, IX_ONE, 3'h7, 1'b1, 1'b0);
      er(PG, 16'h0018, IX_FIVE, 3'h5, 1'b1, 1'b0);
      er(PO, 16'h0001, IX_FIVE, 3'h3, 1'b1, 1'b0);
      final_report;
   end
endmodule

bind fos_top fos_top_monitor u_fos_top_monitor (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .arr_req,
   .arr_we, .arr_info, .arr_addr, .arr_ack, .fetch_in, .fetch_data,
   .fetch_invalid, .command_busy);
